/* File: scpi_status_and_selftest.sv */
// Status groups, error queue, version report and single self-test sequencer.
// Assumes all inputs come from logic on ref_clk_in; the test engine answers
// each test_start_out with exactly one test_done_in pulse.
`timescale 1ns/10ps
`default_nettype none
`include "status_regs.svh"

module scpi_status_and_selftest #(
   parameter logic [15:0] VERSION_YEAR = 16'h07d0, // Arbitrary default, set per build.
   parameter logic [15:0] VERSION_REV = 16'h0000 // Arbitrary default, set per build.
) (
   input wire logic ref_clk_in, // 25 MHz clock.
   input wire logic reset_in, // Synchronous reset, active high.
   input wire logic cmd_valid_in, // Command present.
   input wire status_pkg::cmd_t cmd_code_in, // Command code.
   input wire logic [15:0] cmd_data_in, // Mask, mask or test number.
   input wire logic cal_config_in, // Calibration configure accepted.
   input wire logic cal_done_in, // Matching calibration measurement done.
   input wire logic uncal_mode_in, // Channel set to uncalibrated mode.
   input wire logic cal_test_fail_in, // Channel failed calibration test.
   input wire logic trig_ignored_in, // Trigger was ignored.
   input wire logic armed_in, // Waiting for trigger.
   input wire logic err_push_in, // Error from elsewhere to queue.
   input wire logic [15:0] err_code_in, // Its error number.
   input wire logic test_done_in, // Self-test engine finished.
   input wire logic test_pass_in, // Test passed.
   input wire logic [3:0] wide_address_detail_in, // Failure address detail.
   input wire logic [3:0] test_info_in, // Failure detail.
   output logic cmd_ready_out, // Command can be taken.
   output logic resp_valid_out, // Answer pulse.
   output logic resp_error_out, // Command refused.
   output logic [15:0] resp_data_out, // Answer word.
   output logic [15:0] resp_aux_out, // Version revision.
   output logic [7:0] stb_out, // Status byte.
   output logic srq_out, // Service request.
   output logic test_start_out, // Start pulse to test engine.
   output logic [7:0] test_number_out, // Test to run.
   output logic outputs_off_out // Disable all outputs at zero.
);
   import status_pkg::*;

   state_t st;
   state_t nx;
   logic take;
   logic [15:0] oper_sel;
   logic [15:0] ques_sel;

   assign take = cmd_valid_in & st.cmd_ready;
   assign oper_sel = st.oper_event & st.oper_mask;
   assign ques_sel = st.ques_event & st.ques_mask;

   always_comb begin
      logic [3:0] cnt;
      logic [1:0] pv;
      logic [1:0][15:0] pc;
      logic [7:0] sum;
      cnt = st.err_count;
      pv = {err_push_in, 1'b0};
      pc = {err_code_in, `ERR_NONE};
      sum = 8'h00;
      nx = st;
      nx.resp_valid = 1'b0;
      nx.resp_error = 1'b0;
      nx.test_start = 1'b0;
      nx.outputs_off = 1'b0;
      if (take && cmd_code_in == CMD_RESET) begin
         nx.cal_busy = 1'b0;
      end
      if (cal_done_in) begin
         nx.cal_busy = 1'b0;
      end
      if (cal_config_in) begin
         nx.cal_busy = 1'b1;
      end
      if (take) begin
         nx.resp_valid = 1'b1;
         nx.resp_data = 16'h0000;
         nx.resp_aux = 16'h0000;
         unique case (cmd_code_in)
            CMD_OPER_COND_Q: nx.resp_data = {15'h0000, st.cal_busy};
            CMD_OPER_ENAB_W: nx.oper_mask = cmd_data_in;
            CMD_OPER_ENAB_Q: nx.resp_data = st.oper_mask;
            CMD_OPER_EVENT_Q: begin
               nx.resp_data = st.oper_event;
               nx.oper_event = 16'h0000;
            end
            CMD_QUES_COND_Q: nx.resp_data = 16'h0000;
            CMD_QUES_ENAB_W: nx.ques_mask = cmd_data_in;
            CMD_QUES_ENAB_Q: nx.resp_data = st.ques_mask;
            CMD_QUES_EVENT_Q: begin
               nx.resp_data = st.ques_event;
               nx.ques_event = 16'h0000;
            end
            CMD_PRESET: begin
               nx.oper_mask = `MASK_RESET;
               nx.ques_mask = `MASK_RESET;
            end
            CMD_CLEAR_STATUS: begin
               nx.oper_event = 16'h0000;
               nx.ques_event = 16'h0000;
               cnt = 4'h0;
            end
            CMD_RESET: nx.resp_data = 16'h0000;
            CMD_ERROR_Q: begin
               if (st.err_count != 4'h0) begin
                  nx.resp_data = st.errq[0];
                  cnt = st.err_count - 4'h1;
               end else begin
                  nx.resp_data = `ERR_NONE;
               end
            end
            CMD_VERSION_Q: begin
               nx.resp_data = VERSION_YEAR;
               nx.resp_aux = VERSION_REV;
            end
            CMD_TEST_Q: begin
               if (armed_in) begin
                  nx.resp_error = 1'b1;
                  pv[0] = 1'b1;
                  pc[0] = `ERR_SETTINGS_CONFLICT;
               end else if (cmd_data_in < `TEST_FIRST || cmd_data_in > `TEST_LAST) begin
                  nx.resp_error = 1'b1;
                  pv[0] = 1'b1;
                  pc[0] = `ERR_OUT_OF_RANGE;
               end else begin
                  nx.resp_valid = 1'b0;
                  nx.state = ST_TESTING;
                  nx.cmd_ready = 1'b0;
                  nx.test_start = 1'b1;
                  nx.test_number = cmd_data_in[7:0];
               end
            end
            CMD_SRE_W: nx.sre_mask = cmd_data_in[7:0] & ~(8'h01 << `STB_RQS_BIT);
            CMD_STB_Q: nx.resp_data = {8'h00, st.stb};
         endcase
      end
      unique case (st.state)
         ST_IDLE: nx.cmd_ready = nx.state == ST_IDLE;
         ST_TESTING: begin
            if (test_done_in) begin
               nx.state = ST_IDLE;
               nx.cmd_ready = 1'b1;
               nx.resp_valid = 1'b1;
               nx.resp_aux = 16'h0000;
               nx.outputs_off = 1'b1;
               if (test_pass_in) begin
                  nx.resp_data = 16'h0000;
               end else begin
                  nx.resp_data = {st.test_number, wide_address_detail_in, test_info_in};
               end
            end
         end
      endcase
      // Sources are applied after read and clear so an event is never lost.
      if (nx.cal_busy) begin
         nx.oper_event[`OPER_CAL_BIT] = 1'b1;
      end
      if (uncal_mode_in || cal_test_fail_in) begin
         nx.ques_event[`QUES_CAL_BIT] = 1'b1;
      end
      if (trig_ignored_in) begin
         nx.ques_event[`QUES_TRIG_BIT] = 1'b1;
      end
      if (take && cmd_code_in == CMD_ERROR_Q && st.err_count != 4'h0) begin
         for (int i = 0; i < `ERRQ_DEPTH - 1; i++) begin
            nx.errq[i] = st.errq[i + 1];
         end
         nx.errq[`ERRQ_DEPTH-1] = `ERR_NONE;
      end
      for (int k = 0; k < 2; k++) begin
         if (pv[k]) begin
            if (cnt == `ERRQ_FULL) begin
               nx.errq[`ERRQ_DEPTH-1] = `ERR_QUEUE_OVERFLOW;
            end else begin
               nx.errq[cnt[2:0]] = pc[k];
               cnt = cnt + 4'h1;
            end
         end
      end
      nx.err_count = cnt;
      sum[`STB_OPER_BIT] = |oper_sel;
      sum[`STB_QUES_BIT] = |ques_sel;
      sum[`STB_ERR_BIT] = st.err_count != 4'h0;
      sum[`STB_RQS_BIT] = |(sum & st.sre_mask);
      nx.stb = sum;
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         st <= '0;
         st.state <= ST_IDLE;
         st.oper_mask <= `MASK_RESET;
         st.ques_mask <= `MASK_RESET;
         st.sre_mask <= `SRE_RESET;
         st.cmd_ready <= 1'b1;
      end else begin
         st <= nx;
      end
   end

   assign cmd_ready_out = st.cmd_ready;
   assign resp_valid_out = st.resp_valid;
   assign resp_error_out = st.resp_error;
   assign resp_data_out = st.resp_data;
   assign resp_aux_out = st.resp_aux;
   assign stb_out = st.stb;
   assign srq_out = st.stb[`STB_RQS_BIT];
   assign test_start_out = st.test_start;
   assign test_number_out = st.test_number;
   assign outputs_off_out = st.outputs_off;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (reset_in);

   sequence cal_pending_s;
      cal_config_in && !cal_done_in;
   endsequence

   sequence oper_enab_write_s;
      take && cmd_code_in == CMD_OPER_ENAB_W;
   endsequence

   sequence oper_enab_query_s;
      take && cmd_code_in == CMD_OPER_ENAB_Q;
   endsequence

   sequence ques_request_s;
      st.ques_mask[`QUES_CAL_BIT] && st.ques_event[`QUES_CAL_BIT] && st.sre_mask[`STB_QUES_BIT];
   endsequence

   sequence ques_enab_write_s;
      take && cmd_code_in == CMD_QUES_ENAB_W;
   endsequence

   sequence ques_enab_query_s;
      take && cmd_code_in == CMD_QUES_ENAB_Q;
   endsequence

   sequence test_accept_s;
      take && cmd_code_in == CMD_TEST_Q && !armed_in && cmd_data_in >= `TEST_FIRST && cmd_data_in <= `TEST_LAST;
   endsequence

   sequence test_refuse_s;
      take && cmd_code_in == CMD_TEST_Q && !armed_in && (cmd_data_in < `TEST_FIRST || cmd_data_in > `TEST_LAST);
   endsequence

   cal_condition_a: assert property (cal_pending_s ##1 (!cal_done_in && !(take && cmd_code_in == CMD_RESET))
      |=> st.cal_busy && st.oper_event[`OPER_CAL_BIT])
      else $error("Calibrating bit not held while calibration pending.");

   cond_query_a: assert property (take && cmd_code_in == CMD_OPER_COND_Q && !cal_config_in && !cal_done_in
      |=> resp_valid_out && resp_data_out == {15'h0000, st.cal_busy} && $stable(st.cal_busy))
      else $error("Condition query wrong or disturbed the condition.");

   reset_cond_a: assert property (take && cmd_code_in == CMD_RESET && !cal_config_in |=> !st.cal_busy)
      else $error("Command reset did not clear the condition.");

   oper_summary_a: assert property (##1 stb_out[`STB_OPER_BIT] == |$past(oper_sel))
      else $error("Operation summary bit does not follow masked events.");

   enab_readback_a: assert property (oper_enab_write_s ##1 oper_enab_query_s
      |=> resp_data_out == $past(cmd_data_in, 2))
      else $error("Operation mask did not read back.");

   oper_clear_a: assert property (take && cmd_code_in == CMD_OPER_EVENT_Q && !nx.cal_busy
      |=> resp_data_out == $past(st.oper_event) && st.oper_event == 16'h0000)
      else $error("Operation event query did not return and clear.");

   cls_events_a: assert property (take && cmd_code_in == CMD_CLEAR_STATUS && !nx.cal_busy && !uncal_mode_in
      && !cal_test_fail_in && !trig_ignored_in && !err_push_in
      |=> st.oper_event == 16'h0000 && st.ques_event == 16'h0000 && st.err_count == 4'h0)
      else $error("Clear-status left events or errors.");

   preset_masks_a: assert property (take && cmd_code_in == CMD_PRESET
      && !uncal_mode_in && !cal_test_fail_in && !trig_ignored_in
      |=> st.oper_mask == 16'h0000 && st.ques_mask == 16'h0000 && $stable(st.ques_event))
      else $error("Preset did not zero masks or touched events.");

   ques_cond_a: assert property (take && cmd_code_in == CMD_QUES_COND_Q |=> resp_data_out == 16'h0000)
      else $error("Questionable condition not zero.");

   ques_latch_a: assert property ((uncal_mode_in || cal_test_fail_in)
      |=> st.ques_event[`QUES_CAL_BIT])
      else $error("Calibration problem not latched.");

   service_request_a: assert property (ques_request_s [*2] |-> srq_out && stb_out[`STB_QUES_BIT])
      else $error("Enabled questionable event raised no service request.");

   error_empty_a: assert property (take && cmd_code_in == CMD_ERROR_Q && st.err_count == 4'h0
      |=> resp_valid_out && resp_data_out == `ERR_NONE)
      else $error("Empty error queue did not answer zero.");

   test_reject_a: assert property (take && cmd_code_in == CMD_TEST_Q && armed_in
      |=> resp_valid_out && resp_error_out && !test_start_out && st.state == ST_IDLE)
      else $error("Self-test taken while armed.");

   test_finish_a: assert property (st.state == ST_TESTING && test_done_in
      |=> outputs_off_out && resp_valid_out && cmd_ready_out
      && (resp_data_out == 16'h0000) == $past(test_pass_in))
      else $error("Self-test finish wrong.");

   ques_summary_a: assert property (##1 stb_out[`STB_QUES_BIT] == |$past(ques_sel))
      else $error("Questionable summary bit does not follow masked events.");

   request_form_a: assert property (##1 srq_out == $past(|oper_sel && st.sre_mask[`STB_OPER_BIT]
      || |ques_sel && st.sre_mask[`STB_QUES_BIT] || st.err_count != 4'h0 && st.sre_mask[`STB_ERR_BIT]))
      else $error("Request bit does not follow enabled summaries.");

   sre_write_a: assert property (take && cmd_code_in == CMD_SRE_W
      |=> !st.sre_mask[`STB_RQS_BIT] && st.sre_mask[`STB_QUES_BIT] == $past(cmd_data_in[`STB_QUES_BIT]))
      else $error("Status byte mask write wrong.");

   ques_readback_a: assert property (ques_enab_write_s ##1 ques_enab_query_s
      |=> resp_data_out == $past(cmd_data_in, 2))
      else $error("Questionable mask did not read back.");

   ques_clear_a: assert property (take && cmd_code_in == CMD_QUES_EVENT_Q && !uncal_mode_in
      && !cal_test_fail_in && !trig_ignored_in
      |=> resp_data_out == $past(st.ques_event) && st.ques_event == 16'h0000)
      else $error("Questionable event query did not return and clear.");

   trig_latch_a: assert property (trig_ignored_in |=> st.ques_event[`QUES_TRIG_BIT])
      else $error("Ignored trigger not latched.");

   event_hold_a: assert property (st.ques_event[`QUES_TRIG_BIT]
      && !(take && (cmd_code_in == CMD_QUES_EVENT_Q || cmd_code_in == CMD_CLEAR_STATUS))
      |=> st.ques_event[`QUES_TRIG_BIT])
      else $error("Questionable event bit lost before read or clear.");

   cal_set_a: assert property (cal_config_in |=> st.cal_busy)
      else $error("Calibration configure did not set the calibrating bit.");

   cal_clear_a: assert property (cal_done_in && !cal_config_in |=> !st.cal_busy)
      else $error("Calibrating bit not cleared when measurement done.");

   cond_keep_a: assert property (take && (cmd_code_in == CMD_CLEAR_STATUS || cmd_code_in == CMD_PRESET)
      && !cal_done_in |=> st.cal_busy == ($past(st.cal_busy) || $past(cal_config_in)))
      else $error("Clear or preset disturbed the condition.");

   reset_keeps_a: assert property (take && cmd_code_in == CMD_RESET
      |=> ($past(st.oper_event) & ~st.oper_event) == 16'h0000
      && ($past(st.ques_event) & ~st.ques_event) == 16'h0000 && st.err_count >= $past(st.err_count))
      else $error("Command reset disturbed events or the error queue.");

   error_pop_a: assert property (take && cmd_code_in == CMD_ERROR_Q && st.err_count != 4'h0 && !err_push_in
      |=> resp_data_out == $past(st.errq[0]) && st.err_count == $past(st.err_count) - 4'h1)
      else $error("Error query did not pop the oldest entry.");

   error_flag_a: assert property (##1 stb_out[`STB_ERR_BIT] == ($past(st.err_count) != 4'h0))
      else $error("Error queue flag wrong.");

   version_report_a: assert property (take && cmd_code_in == CMD_VERSION_Q
      |=> resp_data_out == VERSION_YEAR && resp_aux_out == VERSION_REV)
      else $error("Version answer wrong.");

   test_range_a: assert property (test_refuse_s |=> resp_valid_out && resp_error_out && !test_start_out)
      else $error("Out of range self-test not refused.");

   test_start_a: assert property (test_accept_s
      |=> test_start_out && !cmd_ready_out && !resp_valid_out && test_number_out == $past(cmd_data_in[7:0]))
      else $error("Accepted self-test did not start.");

   test_busy_a: assert property (st.state == ST_TESTING && !test_done_in |=> !cmd_ready_out && !resp_valid_out)
      else $error("Command port open while a self-test runs.");

   off_pulse_a: assert property (outputs_off_out |=> !outputs_off_out)
      else $error("Output disable is not a single pulse.");

endmodule : scpi_status_and_selftest
`default_nettype wire

/* File: scpi_status_and_selftest_test.sv */
// Testbench of the status block: a table of plain commands, then hand-written cases.
// Assumes the package, the block and the test engine model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module scpi_status_and_selftest_test;
   import status_pkg::*;
   typedef struct packed {cmd_t code; logic [15:0] data; logic [15:0] exp; logic err; logic chk;} row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic valid = 1'b0;
   logic armed = 1'b0;
   cmd_t code = CMD_STB_Q;
   logic [15:0] data = 16'h0000;
   logic [5:0] ev = 6'h00;
   logic [7:0] fail_num = 8'h4b;
   logic [7:0] delay = 8'h00;
   logic done, pass, rdy, rv, rerr, srq, tst, off, seen_start, seen_busy;
   logic [3:0] addr, info;
   logic [15:0] rdata, raux;
   logic [7:0] stb, tnum, seen_num;
   int miscompares = 0;
   int samples_checked = 0;
   row_t rows [14] = '{'{CMD_OPER_ENAB_W, 16'h0001, 16'h0000, 1'b0, 1'b1}, '{CMD_OPER_ENAB_Q, 16'h0000, 16'h0001, 1'b0, 1'b1},
      '{CMD_QUES_ENAB_W, 16'h0300, 16'h0000, 1'b0, 1'b1}, '{CMD_QUES_ENAB_Q, 16'h0000, 16'h0300, 1'b0, 1'b1},
      '{CMD_QUES_COND_Q, 16'h0000, 16'h0000, 1'b0, 1'b1}, '{CMD_OPER_COND_Q, 16'h0000, 16'h0000, 1'b0, 1'b1},
      '{CMD_ERROR_Q, 16'h0000, 16'h0000, 1'b0, 1'b1}, '{CMD_VERSION_Q, 16'h0000, 16'h07d5, 1'b0, 1'b1},
      '{CMD_SRE_W, 16'h0088, 16'h0000, 1'b0, 1'b1}, '{CMD_TEST_Q, 16'h0000, 16'h0000, 1'b1, 1'b0},
      '{CMD_TEST_Q, 16'h004c, 16'h0000, 1'b1, 1'b0}, '{CMD_ERROR_Q, 16'h0000, 16'hff22, 1'b0, 1'b1},
      '{CMD_ERROR_Q, 16'h0000, 16'hff22, 1'b0, 1'b1}, '{CMD_ERROR_Q, 16'h0000, 16'h0000, 1'b0, 1'b1}};

   scpi_status_and_selftest #(.VERSION_YEAR(16'h07d5), .VERSION_REV(16'h0003))
      i_scpi_status_and_selftest (.ref_clk_in(clk), .reset_in(rst), .cmd_valid_in(valid),
      .cmd_code_in(code), .cmd_data_in(data), .cal_config_in(ev[4]), .cal_done_in(ev[3]), .uncal_mode_in(ev[2]),
      .cal_test_fail_in(ev[1]), .trig_ignored_in(ev[0]), .armed_in(armed), .err_push_in(ev[5]),
      .err_code_in(16'hff9c), .test_done_in(done), .test_pass_in(pass), .wide_address_detail_in(addr),
      .test_info_in(info), .cmd_ready_out(rdy), .resp_valid_out(rv), .resp_error_out(rerr), .resp_data_out(rdata),
      .resp_aux_out(raux), .stb_out(stb), .srq_out(srq), .test_start_out(tst), .test_number_out(tnum),
      .outputs_off_out(off));
   test_engine_model i_test_engine_model (.clk_in(clk), .start_in(tst), .number_in(tnum), .fail_number_in(fail_num),
      .delay_in(delay), .done_out(done), .pass_out(pass), .addr_out(addr), .info_out(info));

   initial begin
      forever #20 clk = ~clk;
   end

   task close_out;
      $display("Counts: %0d mismatches in %0d comparisons", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out

   task check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // Presents one command, then waits a bounded time for its answer pulse.
   task run(input cmd_t c, input logic [15:0] d);
      int n;
      @(posedge clk);
      valid <= 1'b1;
      code <= c;
      data <= d;
      @(posedge clk);
      valid <= 1'b0;
      seen_start = 1'b0;
      seen_busy = 1'b0;
      seen_num = 8'h00;
      #1;
      for (n = 0; n < 200 && rv !== 1'b1; n++) begin
         if (tst === 1'b1) begin
            seen_start = 1'b1;
            seen_num = tnum;
         end
         seen_busy |= (rdy === 1'b0);
         @(posedge clk);
         #1;
      end
      if (rv !== 1'b1) begin
         check(16'h0000, 16'h0001);
         close_out();
      end
   endtask : run

   task q(input cmd_t c, input logic [15:0] d, input logic [15:0] exp);
      run(c, d);
      check({15'h0000, rerr}, 16'h0000);
      check(rdata, exp);
   endtask : q

   task tq(input logic [15:0] d, input logic [15:0] exp);
      run(CMD_TEST_Q, d);
      check(rdata, exp);
      check({12'h000, off, seen_start, seen_busy, rerr}, 16'h000e);
      check({8'h00, seen_num}, d);
   endtask : tq

   // Presents two commands on back-to-back edges and checks the second answer.
   task pair(input cmd_t c, input logic [15:0] d, input cmd_t c2, input logic [15:0] exp);
      @(posedge clk);
      valid <= 1'b1;
      code <= c;
      data <= d;
      @(posedge clk);
      code <= c2;
      @(posedge clk);
      valid <= 1'b0;
      #1;
      check({15'h0000, rv}, 16'h0001);
      check(rdata, exp);
   endtask : pair

   // Pulses event inputs for one cycle, then lets the status byte settle.
   task pulse(input logic [5:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 6'h00;
      repeat (3) @(posedge clk);
      #1;
   endtask : pulse

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      #1;
      check({7'h00, rdy, stb}, 16'h0100);
      foreach (rows[i]) begin
         run(rows[i].code, rows[i].data);
         check({15'h0000, rerr}, {15'h0000, rows[i].err});
         if (rows[i].chk) check(rdata, rows[i].exp);
      end
      check(raux, 16'h0000);
      q(CMD_VERSION_Q, 16'h0000, 16'h07d5);
      check(raux, 16'h0003);
      pair(CMD_OPER_ENAB_W, 16'h8001, CMD_OPER_ENAB_Q, 16'h8001);
      pair(CMD_QUES_ENAB_W, 16'h0300, CMD_QUES_ENAB_Q, 16'h0300);
      pulse(6'h10);
      check({8'h00, stb}, 16'h00c0);
      check({15'h0000, srq}, 16'h0001);
      q(CMD_OPER_COND_Q, 16'h0000, 16'h0001);
      q(CMD_OPER_COND_Q, 16'h0000, 16'h0001);
      pulse(6'h08);
      q(CMD_OPER_COND_Q, 16'h0000, 16'h0000);
      q(CMD_OPER_EVENT_Q, 16'h0000, 16'h0001);
      q(CMD_OPER_EVENT_Q, 16'h0000, 16'h0000);
      pulse(6'h00);
      check({8'h00, stb}, 16'h0000);
      pulse(6'h04);
      pulse(6'h01);
      check({8'h00, stb}, 16'h0048);
      q(CMD_QUES_EVENT_Q, 16'h0000, 16'h0300);
      q(CMD_QUES_EVENT_Q, 16'h0000, 16'h0000);
      pulse(6'h02);
      q(CMD_QUES_COND_Q, 16'h0000, 16'h0000);
      q(CMD_QUES_EVENT_Q, 16'h0000, 16'h0100);
      pulse(6'h01);
      q(CMD_PRESET, 16'h0000, 16'h0000);
      pulse(6'h00);
      check({8'h00, stb}, 16'h0000);
      q(CMD_OPER_ENAB_Q, 16'h0000, 16'h0000);
      q(CMD_QUES_ENAB_Q, 16'h0000, 16'h0000);
      q(CMD_QUES_EVENT_Q, 16'h0000, 16'h0200);
      pulse(6'h11);
      q(CMD_RESET, 16'h0000, 16'h0000);
      q(CMD_OPER_COND_Q, 16'h0000, 16'h0000);
      q(CMD_QUES_EVENT_Q, 16'h0000, 16'h0200);
      q(CMD_OPER_EVENT_Q, 16'h0000, 16'h0001);
      pulse(6'h20);
      q(CMD_RESET, 16'h0000, 16'h0000);
      q(CMD_ERROR_Q, 16'h0000, 16'hff9c);
      pulse(6'h31);
      q(CMD_CLEAR_STATUS, 16'h0000, 16'h0000);
      q(CMD_OPER_COND_Q, 16'h0000, 16'h0001);
      q(CMD_QUES_EVENT_Q, 16'h0000, 16'h0000);
      q(CMD_ERROR_Q, 16'h0000, 16'h0000);
      pulse(6'h08);
      q(CMD_CLEAR_STATUS, 16'h0000, 16'h0000);
      q(CMD_OPER_EVENT_Q, 16'h0000, 16'h0000);
      tq(16'h0005, 16'h0000);
      delay <= 8'd20;
      tq(16'h004b, 16'h4b5a);
      tq(16'h0001, 16'h0000);
      @(posedge clk);
      armed <= 1'b1;
      run(CMD_TEST_Q, 16'h0005);
      check({14'h0000, rerr, seen_start}, 16'h0002);
      @(posedge clk);
      armed <= 1'b0;
      q(CMD_ERROR_Q, 16'h0000, 16'hff23);
      close_out();
   end
endmodule : scpi_status_and_selftest_test
`default_nettype wire

/* File: status_pkg.sv */
// Types of the status reporting and single self-test block.
// Assumes the constants header is on the include path.
`include "status_regs.svh"

package status_pkg;

   typedef enum logic [3:0] {
      CMD_OPER_COND_Q,
      CMD_OPER_ENAB_W,
      CMD_OPER_ENAB_Q,
      CMD_OPER_EVENT_Q,
      CMD_QUES_COND_Q,
      CMD_QUES_ENAB_W,
      CMD_QUES_ENAB_Q,
      CMD_QUES_EVENT_Q,
      CMD_PRESET,
      CMD_CLEAR_STATUS,
      CMD_RESET,
      CMD_ERROR_Q,
      CMD_VERSION_Q,
      CMD_TEST_Q,
      CMD_SRE_W,
      CMD_STB_Q
   } cmd_t;

   typedef enum logic {ST_IDLE, ST_TESTING} test_state_t;

   typedef struct packed {
      test_state_t state;
      logic cal_busy;
      logic [15:0] oper_event;
      logic [15:0] oper_mask;
      logic [15:0] ques_event;
      logic [15:0] ques_mask;
      logic [7:0] sre_mask;
      logic [`ERRQ_DEPTH-1:0][15:0] errq;
      logic [3:0] err_count;
      logic cmd_ready;
      logic resp_valid;
      logic resp_error;
      logic [15:0] resp_data;
      logic [15:0] resp_aux;
      logic test_start;
      logic [7:0] test_number;
      logic outputs_off;
      logic [7:0] stb;
   } state_t;

endpackage : status_pkg

/* File: status_regs.svh */
// Constants of the status reporting and single self-test block.
// Assumes inclusion by the package and by the block; definitions only.
//
// Overview of operation
// - Calibrating condition bit 0 while calibration pending.
// - Condition query returns 16 bits, no side effect.
// - Command reset clears conditions; clear/preset do not.
// - Status bit 7 ORs masked operation events.
// - Operation mask query returns stored mask.
// - Operation event query returns then clears bits.
// - Clear-status clears operation events; reset keeps them.
// - Preset zeroes masks, keeps conditions and events.
// - Questionable condition query always returns zero.
// - Questionable bit 8 calibration, bit 9 ignored trigger.
// - Status bit 3 ORs masked questionable events.
// - Enabled bit 3 raises request bit 6, service request.
// - Uncalibrated mode or failed test sets bit 8.
// - Questionable event query returns then clears bits.
// - Clear-status clears questionable events; reset keeps them.
// - Error query pops entry or zero; clear empties queue.
// - Version query reports year and revision.
// - Single self-test numbered 1 to 75, 16-bit result.
// - After self-test all outputs disabled at zero.
// - Self-test refused with error while armed.
// - Pass returns zero; failure packs number and details.
`ifndef STATUS_REGS_SVH
`define STATUS_REGS_SVH

`define OPER_CAL_BIT 0
`define QUES_CAL_BIT 8
`define QUES_TRIG_BIT 9
`define STB_ERR_BIT 2
`define STB_QUES_BIT 3
`define STB_RQS_BIT 6
`define STB_OPER_BIT 7
`define MASK_RESET 16'h0000
`define SRE_RESET 8'h00
`define TEST_FIRST 16'h0001
`define TEST_LAST 16'h004b
`define ERRQ_DEPTH 8
`define ERRQ_FULL 4'h8
`define ERR_NONE 16'h0000
`define ERR_SETTINGS_CONFLICT 16'hff23
`define ERR_OUT_OF_RANGE 16'hff22
`define ERR_QUEUE_OVERFLOW 16'hfea2

`endif

/* File: test_engine_model.sv */
// Behavioural self-test engine on the far side of the start/done handshake.
// Assumes one clock shared with the block; failing test and latency come from the bench.
`timescale 1ns/10ps
`default_nettype none
module test_engine_model (
   input wire logic clk_in, // Shared clock.
   input wire logic start_in, // Start pulse.
   input wire logic [7:0] number_in, // Test to run.
   input wire logic [7:0] fail_number_in, // Test that reports a failure.
   input wire logic [7:0] delay_in, // Cycles before the answer.
   output logic done_out, // Finished pulse.
   output logic pass_out, // Result, valid with done_out.
   output logic [3:0] addr_out, // Address detail, valid with done_out.
   output logic [3:0] info_out // Failure detail, valid with done_out.
);
   logic busy = 1'b0;
   logic done = 1'b0;
   logic pass = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [3:0] info = 4'h0;
   logic [7:0] count = 8'h00;
   logic [7:0] number = 8'h00;
   assign done_out = done;
   assign pass_out = pass;
   assign addr_out = addr;
   assign info_out = info;
   // Result lines flip outside done so a stale value is never taken for an answer.
   always @(posedge clk_in) begin
      done <= 1'b0;
      pass <= ~pass;
      addr <= ~addr;
      info <= ~info;
      if (start_in === 1'b1) begin
         busy <= 1'b1;
         count <= delay_in;
         number <= number_in;
      end else if (busy && count != 8'h00) begin
         count <= count - 8'h01;
      end else if (busy) begin
         busy <= 1'b0;
         done <= 1'b1;
         pass <= (number != fail_number_in);
         addr <= 4'h5;
         info <= 4'ha;
      end
   end
endmodule : test_engine_model
`default_nettype wire
